// ===== logic/min_track_pkg.sv
// Purpose: shared constants and types for the per-channel lowest-code tracker
// Assumes: 8-bit register port, 16-bit msb-aligned code storage per channel
// Notes: channels 2 to 5 are tracked; channel 2 exposes only its upper byte here
`default_nettype none
package min_track_pkg;
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned FIRST_CH = 2;
	localparam logic [7:0] ADDR_CH2_HIGH = 8'h85;
	localparam logic [7:0] ADDR_CH3_LOW = 8'h86;
	localparam logic [7:0] ADDR_CH3_HIGH = 8'h87;
	localparam logic [7:0] ADDR_CH4_LOW = 8'h88;
	localparam logic [7:0] ADDR_CH4_HIGH = 8'h89;
	localparam logic [7:0] ADDR_CH5_LOW = 8'h8A;
	localparam logic [7:0] ADDR_CH5_HIGH = 8'h8B;
	localparam logic [7:0] BYTE_RESET = 8'hFF;
	localparam logic [15:0] PAIR_RESET = 16'hFFFF;
	localparam int unsigned CODE_W = 12;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	typedef struct packed {
		logic valid;
		logic [2:0] channel;
		logic [CODE_W-1:0] code;
	} conv_result_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic rvalid;
	} reg_rsp_t;
endpackage
`default_nettype wire

// ===== logic/lowest_code_slot.sv
// Purpose: one channel's lowest-code holding register pair
// Assumes: sample and reload strobes are single-cycle
// Notes: reload wins over a same-cycle sample, then the sample is kept
`timescale 1ns/1ps
`default_nettype none
module lowest_code_slot
	import min_track_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sample,
	input wire logic [15:0] sample_code,
	input wire logic reload,
	output logic [15:0] stored
);
	typedef struct packed {
		logic [15:0] value;
	} slot_state_t;

	slot_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (reload) begin
			// a sample landing with the read is not lost: it starts the new window
			s_d.value = sample ? sample_code : PAIR_RESET;
		end else if (sample && (sample_code < s_q.value)) begin
			s_d.value = sample_code;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_q.value <= PAIR_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign stored = s_q.value;
endmodule // lowest_code_slot
`default_nettype wire

// ===== logic/channel_minimum_tracker.sv
// Purpose: per-channel lowest conversion code trackers behind the register port
// Assumes: one register access per cycle; read data answers one cycle later
// Notes: either byte of a pair reloads both bytes of that pair
// Behaviour
// [RULE1] keep smaller of new code and stored
// [RULE2] read returns value then reloads 0xFF
// [RULE3] reset leaves every byte all ones
// [RULE4] channel 3-5 bytes at 0x86 to 0x8B
// [RULE5] registers read-only, all eight bits data; the code holds bits 3:0 of each low byte at zero once a code is stored
// [RULE6] msb-aligned pair, either read reloads both
`timescale 1ns/1ps
`default_nettype none
module channel_minimum_tracker
	import min_track_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire conv_result_t conv,
	input wire reg_req_t req,
	output reg_rsp_t rsp
);
	typedef struct packed {
		reg_rsp_t rsp;
	} top_state_t;

	top_state_t s_q, s_d;
	logic [NUM_CH-1:0] hit;
	logic [NUM_CH-1:0] sample;
	logic [15:0] stored [NUM_CH];
	logic [15:0] aligned;

	// msb-aligned: the 12-bit code fills the upper bits, low nibble zero
	assign aligned = {conv.code, 4'h0}; // [RULE6]

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			localparam logic [2:0] CH = 3'(FIRST_CH + g);
			localparam logic [7:0] LOW_A = 8'(ADDR_CH3_LOW + 2 * (g - 1));
			localparam logic [7:0] HIGH_A = 8'(ADDR_CH3_HIGH + 2 * (g - 1));
			assign sample[g] = conv.valid && (conv.channel == CH); // [RULE1]
			// writes never reach the slot, so the registers stay read-only
			// channel 2 has no low byte in this map, so only its high byte may reload it
			assign hit[g] = req.rd && ((req.addr == HIGH_A) // [RULE6]
				|| ((g != 0) && (req.addr == LOW_A)));
			lowest_code_slot u_slot (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.sample(sample[g]),
				.sample_code(aligned),
				.reload(hit[g]), // [RULE2]
				.stored(stored[g])
			);

			// per-slot checks: every channel, not just a sample of them
			property p_slot_reset;
				@(posedge ref_clk) $rose(rst_n) |-> (stored[g] == PAIR_RESET);
			endproperty
			a_slot_reset: assert property (p_slot_reset) // [RULE3]
				else $error("slot not all ones after reset");

			property p_slot_takes;
				@(posedge ref_clk) disable iff (!rst_n)
				(sample[g] && !hit[g] && (aligned < stored[g])) |=> (stored[g] == $past(aligned));
			endproperty
			a_slot_takes: assert property (p_slot_takes) // [RULE1]
				else $error("smaller code not taken");

			property p_slot_keeps;
				@(posedge ref_clk) disable iff (!rst_n)
				(sample[g] && !hit[g] && (aligned >= stored[g])) |=> (stored[g] == $past(stored[g]));
			endproperty
			a_slot_keeps: assert property (p_slot_keeps) // [RULE1]
				else $error("larger code replaced minimum");

			property p_slot_reload;
				@(posedge ref_clk) disable iff (!rst_n)
				(hit[g] && !sample[g]) |=> (stored[g] == PAIR_RESET);
			endproperty
			a_slot_reload: assert property (p_slot_reload) // [RULE2]
				else $error("slot not reloaded by read");

			property p_slot_collide;
				@(posedge ref_clk) disable iff (!rst_n)
				(hit[g] && sample[g]) |=> (stored[g] == $past(aligned));
			endproperty
			a_slot_collide: assert property (p_slot_collide) // [RULE2]
				else $error("sample lost at read");

			property p_slot_hold;
				@(posedge ref_clk) disable iff (!rst_n)
				(!hit[g] && !sample[g]) |=> (stored[g] == $past(stored[g]));
			endproperty
			a_slot_hold: assert property (p_slot_hold) // [RULE5]
				else $error("slot changed without cause");

			property p_slot_high_read;
				@(posedge ref_clk) disable iff (!rst_n)
				(req.rd && (req.addr == HIGH_A)) |=> (rsp.rdata == $past(stored[g][15:8]));
			endproperty
			a_slot_high_read: assert property (p_slot_high_read) // [RULE4]
				else $error("high byte read wrong");

			property p_slot_low_read;
				@(posedge ref_clk) disable iff (!rst_n)
				((g != 0) && req.rd && (req.addr == LOW_A)) |=> (rsp.rdata == $past(stored[g][7:0]));
			endproperty
			a_slot_low_read: assert property (p_slot_low_read) // [RULE4]
				else $error("low byte read wrong");
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		s_d.rsp.rvalid = req.rd;
		s_d.rsp.rdata = UNMAPPED_DATA;
		if (req.rd) begin
			case (req.addr) // [RULE4]
				ADDR_CH2_HIGH: s_d.rsp.rdata = stored[0][15:8];
				ADDR_CH3_LOW: s_d.rsp.rdata = stored[1][7:0];
				ADDR_CH3_HIGH: s_d.rsp.rdata = stored[1][15:8];
				ADDR_CH4_LOW: s_d.rsp.rdata = stored[2][7:0];
				ADDR_CH4_HIGH: s_d.rsp.rdata = stored[2][15:8];
				ADDR_CH5_LOW: s_d.rsp.rdata = stored[3][7:0];
				ADDR_CH5_HIGH: s_d.rsp.rdata = stored[3][15:8]; // [RULE5]
				default: s_d.rsp.rdata = UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_q.rsp.rdata <= 8'h00;
			s_q.rsp.rvalid <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rsp = s_q.rsp;

	// reset checks look at the first edge after release, before any request can land
	property p_reset_all_ones;
		@(posedge ref_clk) $rose(rst_n)
		|-> (stored[1] == PAIR_RESET) && (stored[3] == PAIR_RESET);
	endproperty
	a_reset_all_ones: assert property (p_reset_all_ones) // [RULE3]
		else $error("tracker not all ones after reset");

	property p_reset_rsp;
		@(posedge ref_clk) $rose(rst_n) |-> (!rsp.rvalid && (rsp.rdata == 8'h00));
	endproperty
	a_reset_rsp: assert property (p_reset_rsp) // [RULE3]
		else $error("response not idle after reset");

	property p_read_returns;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.rd && req.addr == ADDR_CH4_HIGH) |=> (rsp.rvalid && rsp.rdata == $past(stored[2][15:8]));
	endproperty
	a_read_returns: assert property (p_read_returns) // [RULE2]
		else $error("read data mismatch");

	property p_read_reloads;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.rd && req.addr == ADDR_CH3_LOW && !sample[1]) |=> (stored[1] == PAIR_RESET);
	endproperty
	a_read_reloads: assert property (p_read_reloads) // [RULE6]
		else $error("pair not reloaded");

	property p_keeps_min;
		@(posedge ref_clk) disable iff (!rst_n)
		(sample[3] && !hit[3])
		|=> (stored[3] <= $past(stored[3])) && (stored[3] <= $past(aligned));
	endproperty
	a_keeps_min: assert property (p_keeps_min) // [RULE1]
		else $error("minimum not kept");

	property p_no_rise;
		@(posedge ref_clk) disable iff (!rst_n)
		(!hit[2]) |=> (stored[2] <= $past(stored[2]));
	endproperty
	a_no_rise: assert property (p_no_rise) // [RULE5]
		else $error("tracked value rose");

	property p_write_ignored;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.wr && !req.rd && !conv.valid) |=> (stored[1] == $past(stored[1]));
	endproperty
	a_write_ignored: assert property (p_write_ignored) // [RULE5]
		else $error("write changed tracker");

	property p_unmapped_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.rd && req.addr == 8'h8C) |=> (rsp.rdata == UNMAPPED_DATA);
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) // [RULE4]
		else $error("unmapped read not zero");

	property p_msb_aligned;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.rd && req.addr == ADDR_CH5_LOW && stored[3] != PAIR_RESET) |=> (rsp.rdata[3:0] == 4'h0);
	endproperty
	a_msb_aligned: assert property (p_msb_aligned) // [RULE6]
		else $error("low nibble not zero");

	property p_rvalid_follows;
		@(posedge ref_clk) disable iff (!rst_n)
		req.rd |=> rsp.rvalid;
	endproperty
	a_rvalid_follows: assert property (p_rvalid_follows) // [RULE4]
		else $error("read not answered");

	// a write gets no answer at all, so a host cannot mistake it for a read
	property p_rvalid_idle;
		@(posedge ref_clk) disable iff (!rst_n)
		!req.rd |=> (!rsp.rvalid && (rsp.rdata == UNMAPPED_DATA));
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle) // [RULE5]
		else $error("answer without read");

	property p_ch2_low_quiet;
		@(posedge ref_clk) disable iff (!rst_n)
		(req.rd && (req.addr == ADDR_CH2_HIGH - 8'h01) && !sample[0]) |=> (stored[0] == $past(stored[0]));
	endproperty
	a_ch2_low_quiet: assert property (p_ch2_low_quiet) // [RULE4]
		else $error("undecoded byte reloaded channel 2");

	c_read: cover property (@(posedge ref_clk) req.rd && req.addr == ADDR_CH3_HIGH);
	c_update: cover property (@(posedge ref_clk) sample[2] && aligned < stored[2]);
	c_collide: cover property (@(posedge ref_clk) sample[1] && hit[1]);
	c_unmapped: cover property (@(posedge ref_clk) req.rd && req.addr == 8'h8C);
	c_write: cover property (@(posedge ref_clk) req.wr && !req.rd);
endmodule // channel_minimum_tracker
`default_nettype wire

// ===== test/host_reader.sv
// Purpose: host side of the register port
// Assumes: one access in flight, answer one cycle after the read edge
// Notes: address is inverted on release so a stale decode cannot pass
`timescale 1ns/1ps
`default_nettype none
module host_reader
	import min_track_pkg::*;
(
	input wire logic ref_clk,
	input wire reg_rsp_t rsp,
	output reg_req_t req
);
	initial req = '0;
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk) req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge ref_clk) req <= '{1'b0, 1'b0, ~a, 8'h00};
		#1 d = rsp.rdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk) req <= '{1'b0, 1'b1, a, v};
		@(posedge ref_clk) req <= '{1'b0, 1'b0, ~a, ~v};
	endtask
endmodule // host_reader
`default_nettype wire

// ===== test/testbench.sv
// Purpose: self-checking bench for channel_minimum_tracker
// Assumes: codes are stored msb-aligned, reads answer one cycle later
// Notes: a pair shares one reload, so read order is part of each check
`timescale 1ns/1ps
`default_nettype none
module testbench
	import min_track_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	conv_result_t conv = '0;
	reg_req_t req;
	reg_rsp_t rsp;
	int n_fail = 0;
	int comparisons = 0;
	logic [7:0] d;
	always #50 ref_clk = ~ref_clk;
	channel_minimum_tracker DUT (.ref_clk(ref_clk), .rst_n(rst_n), .conv(conv), .req(req),
		.rsp(rsp));
	host_reader HOST (.ref_clk(ref_clk), .rsp(rsp), .req(req));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cv(input logic [2:0] ch, input logic [11:0] c);
		@(posedge ref_clk) conv <= '{1'b1, ch, c};
		@(posedge ref_clk) conv <= '0;
	endtask
	task automatic t_reset();
		for (int a = 'h85; a <= 'h8B; a++) begin
			HOST.rd(8'(a), d);
			chk(d, BYTE_RESET);
		end
		$display("reset test done");
	endtask
	task automatic t_track();
		for (int ch = 3; ch <= 5; ch++) begin
			cv(3'(ch), 12'h7E3);
			cv(3'(ch), 12'h7E1);
			cv(3'(ch), 12'h7F0);
			// a leak from an untracked channel would read back 0x20, not 0x10
			cv(3'(ch + 3), 12'h002);
			HOST.rd(8'(ch * 2 + 'h80), d);
			chk(d, 8'h10);
			HOST.rd(8'(ch * 2 + 'h81), d);
			chk(d, BYTE_RESET);
		end
		cv(3'd2, 12'h5A0);
		HOST.rd(8'h85, d);
		chk(d, 8'h5A);
		HOST.rd(8'h85, d);
		chk(d, BYTE_RESET);
		$display("track test done");
	endtask
	task automatic t_write();
		cv(3'd4, 12'h123);
		HOST.wr(8'h88, 8'h00);
		HOST.wr(8'h89, 8'h00);
		HOST.rd(8'h89, d);
		chk(d, 8'h12);
		HOST.rd(8'h8C, d);
		chk(d, UNMAPPED_DATA);
		chk({7'h00, rsp.rvalid}, 8'h01);
		// the undecoded channel 2 low byte answers zero and leaves the pair alone
		cv(3'd2, 12'h300);
		HOST.rd(8'h84, d);
		chk(d, UNMAPPED_DATA);
		HOST.rd(8'h85, d);
		chk(d, 8'h30);
		$display("write test done");
	endtask
	task automatic t_collide();
		// a result landing with the read opens the new window instead of being lost
		fork
			cv(3'd3, 12'h400);
			HOST.rd(8'h87, d);
		join
		chk(d, BYTE_RESET);
		HOST.rd(8'h87, d);
		chk(d, 8'h40);
		$display("collide test done");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d failures %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_track();
		t_write();
		t_collide();
		print_verdict();
	end
	// the tests need some 90 cycles; the 1500-cycle limit marks a hang
	initial begin
		#150_000;
		n_fail++;
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
